/* File: shared/adc_ctl_pkg.sv */
// Purpose: Constants for the converter control block.
// Assumes: AHB-Lite register access, 32-bit words.
// Notes: Offsets are byte addresses.
package adc_ctl_pkg;
   localparam logic [7:0] OFF_STATUS_CTRL = 8'h00;
   localparam logic [7:0] OFF_CONFIG = 8'h04;
   localparam logic [7:0] OFF_RESULT_HIGH = 8'h08;
   localparam logic [7:0] OFF_RESULT_LOW = 8'h0C;
   localparam logic [7:0] OFF_COMPARE = 8'h10;
   localparam logic [7:0] OFF_PIN_DISABLE_HI = 8'h14;
   localparam logic [4:0] CHAN_ALL_ONES = 5'h1F;
   localparam logic [1:0] CLKSEL_BUS = 2'h0;
   localparam logic [1:0] CLKSEL_BUS_HALF = 2'h1;
   localparam logic [1:0] CLKSEL_ALT = 2'h2;
   localparam logic [1:0] CLKSEL_ASYNC = 2'h3;
   localparam logic [1:0] RES_8BIT = 2'h0;
   localparam logic [1:0] RES_10BIT = 2'h2;
   localparam logic [7:0] PIN_DISABLE_RESET = 8'h00;
   localparam logic [4:0] CONV_CYCLES = 5'h17;
   typedef enum logic [1:0] {ST_DISABLED, ST_IDLE, ST_CONVERT} conv_state_e;
endpackage

/* File: hdl/adc_clock_divider.sv */
// Purpose: Select the converter clock source and divide it into an enable tick.
// Assumes: Sources other than the bus clock arrive as bus-synchronous enables.
// Notes: The tick marks one converter clock period.
`timescale 1ns/10ps
module adc_clock_divider
   import adc_ctl_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic [1:0] input_clock_select,
   input wire logic [1:0] clock_divide_select,
   input wire logic alt_tick,
   input wire logic async_tick,
   output logic tick
);
   logic half_q;
   logic src_tick;
   logic [2:0] cnt_q;
   logic [2:0] limit;
   // Bus clock, bus clock halved, alternate or internal asynchronous source.
   assign src_tick = (input_clock_select == CLKSEL_BUS) ? 1'b1 :
                     (input_clock_select == CLKSEL_BUS_HALF) ? half_q :
                     (input_clock_select == CLKSEL_ALT) ? alt_tick : async_tick;
   // Divide by 1, 2, 4 or 8; with the halved source this reaches one sixteenth.
   assign limit = 3'((4'h1 << clock_divide_select) - 4'h1);
   assign tick = run && src_tick && (cnt_q == limit);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         half_q <= 1'b0;
         cnt_q <= 3'h0;
      end else begin
         half_q <= run ? ~half_q : 1'b0;
         if (!run) begin
            cnt_q <= 3'h0;
         end else if (src_tick) begin
            cnt_q <= (cnt_q == limit) ? 3'h0 : 3'(cnt_q + 3'h1);
         end
      end
   end
   a_div_limit: assert property (@(posedge clk) disable iff (!rst_n)
      run |-> (cnt_q <= limit)) else $error("Divider count out of range.");
endmodule

/* File: hdl/adc_control.sv */
// Purpose: Converter control with AHB-Lite registers, pin disable and hardware trigger.
// Assumes: Single word transfers; the analog core delivers an 11-bit sample on request.
// Notes: Zero wait states; every access answers OKAY.
//
// Local design decisions: register access over AHB-Lite and the address map.
`timescale 1ns/10ps
// What this block does
// - Pin-disable register bits 7..0 map channels 23..16; one disables port control.
// - Converter stays disabled during reset and when channel select is all ones.
// - Between conversions the converter sits idle in lowest power.
// - Ten-bit mode rounds the 11-bit result and fills high and low results.
// - Eight-bit mode rounds the 9-bit result into the low result only.
// - Stored result sets the complete flag; interrupt when enabled.
// - Compare enable activates result comparison in every mode.
// - Clock select picks one of four sources; bus clock after reset.
// - Clock select codes: 00 bus, 01 half, 10 alternate, 11 asynchronous.
// - Halved source with divider reaches one sixteenth of bus clock.
// - Internal asynchronous clock keeps running in wait and stop3 when selected.
// - Selected source divides by 1, 2, 4 or 8.
// - Divide codes: 00 one, 01 two, 10 four, 11 eight.
// - Resolution codes: 00 eight bit, 10 ten bit, others reserved.
// - Disabled pin has output high impedance and pull-up off.
// - Disabled pin input buffer off; port read returns zero.
// - With trigger enabled a rising trigger edge starts a conversion.
// - Trigger edges during a running conversion are ignored.
// - In continuous triggered mode only the launching edge counts.
module adc_control
   import adc_ctl_pkg::*;
#(
   parameter int CHANNELS = 8
)
(
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire logic HW_TRIGGER_INPUT,
   input wire logic ALT_CLOCK_TICK,
   input wire logic ASYNC_CLOCK_TICK,
   input wire logic LOW_POWER_MODE,
   input wire logic [10:0] SAMPLE_VALUE,
   input wire logic [CHANNELS-1:0] PORT_OUT_ENABLE,
   input wire logic [CHANNELS-1:0] PORT_PULLUP_ENABLE,
   input wire logic [CHANNELS-1:0] PIN_INPUT,
   output logic [CHANNELS-1:0] PIN_OUT_ENABLE,
   output logic [CHANNELS-1:0] PIN_PULLUP_ENABLE,
   output logic [CHANNELS-1:0] PIN_INPUT_BUFFER_ENABLE,
   output logic [CHANNELS-1:0] PORT_READ_DATA,
   output logic CONVERTER_ACTIVE,
   output logic ASYNC_CLOCK_ENABLE,
   output logic COMPLETE_IRQ
);
   if (CHANNELS != 8) begin : g_bad_channels
      $error("CHANNELS must be 8.");
   end
   logic rst_meta_q, rst_sync_q, rst_n;
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end
   assign rst_n = rst_sync_q;

   logic [4:0] channel_select_q;
   logic complete_irq_enable_q, conversion_complete_flag_q, continuous_q;
   logic compare_enable_q, compare_greater_q, hw_trigger_enable_q;
   logic [1:0] input_clock_select_q, clock_divide_select_q, resolution_q;
   logic [9:0] compare_value_q;
   logic [9:0] result_q;
   logic [7:0] analog_pin_disable_hi_q;
   logic ph_valid_q, ph_write_q;
   logic [7:0] ph_addr_q;
   conv_state_e state_q;

   wire addr_ok = HSEL && HREADY && HTRANS[1];
   wire wr_sc1 = ph_valid_q && ph_write_q && (ph_addr_q == OFF_STATUS_CTRL);
   wire wr_cfg = ph_valid_q && ph_write_q && (ph_addr_q == OFF_CONFIG);
   wire wr_cmp = ph_valid_q && ph_write_q && (ph_addr_q == OFF_COMPARE);
   wire wr_pin = ph_valid_q && ph_write_q && (ph_addr_q == OFF_PIN_DISABLE_HI);
   wire rd_low = ph_valid_q && !ph_write_q && (ph_addr_q == OFF_RESULT_LOW);
   wire enabled = (channel_select_q != CHAN_ALL_ONES);
   wire res10 = (resolution_q == RES_10BIT);

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         ph_valid_q <= 1'b0;
         ph_write_q <= 1'b0;
         ph_addr_q <= 8'h00;
      end else begin
         ph_valid_q <= addr_ok;
         ph_write_q <= HWRITE;
         ph_addr_q <= HADDR[7:0];
      end
   end
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;

   // Hardware trigger synchroniser and edge detector.
   logic trig_meta_q, trig_sync_q, trig_prev_q;
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         trig_meta_q <= 1'b0;
         trig_sync_q <= 1'b0;
         trig_prev_q <= 1'b0;
      end else begin
         trig_meta_q <= HW_TRIGGER_INPUT;
         trig_sync_q <= trig_meta_q;
         trig_prev_q <= trig_sync_q;
      end
   end
   wire trig_rise = trig_sync_q && !trig_prev_q;
   // Edges are honoured only from idle, so a running or continuous sequence ignores them.
   wire hw_start = hw_trigger_enable_q && trig_rise && (state_q == ST_IDLE);
   wire sw_start = wr_sc1 && !hw_trigger_enable_q && (HWDATA[4:0] != CHAN_ALL_ONES);

   logic conv_tick;
   logic [4:0] conv_cnt_q;
   wire running = (state_q == ST_CONVERT);
   adc_clock_divider u_div (
      .clk(CLK),
      .rst_n(rst_n),
      .run(running),
      .input_clock_select(input_clock_select_q),
      .clock_divide_select(clock_divide_select_q),
      .alt_tick(ALT_CLOCK_TICK),
      .async_tick(ASYNC_CLOCK_TICK),
      .tick(conv_tick)
   );
   wire conv_done = running && conv_tick && (conv_cnt_q == CONV_CYCLES);

   // Rounding: add half an LSB and saturate.
   wire [11:0] round10 = {1'b0, SAMPLE_VALUE} + 12'h001;
   wire [9:0] r10 = round10[11] ? 10'h3FF : round10[10:1];
   wire [9:0] round8 = {1'b0, SAMPLE_VALUE[10:2]} + 10'h001;
   wire [7:0] r8 = round8[9] ? 8'hFF : round8[8:1];
   wire [9:0] rounded = res10 ? r10 : {2'b00, r8};
   wire [9:0] cmp_val = res10 ? compare_value_q : {2'b00, compare_value_q[7:0]};
   wire [10:0] diff = {1'b0, rounded} + {1'b0, ~cmp_val} + 11'h001;
   wire cmp_ge = diff[10];
   wire cmp_true = compare_greater_q ? cmp_ge : !cmp_ge;
   wire [9:0] cmp_res = res10 ? diff[9:0] : {2'b00, diff[7:0]};
   wire store = conv_done && (!compare_enable_q || cmp_true);

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_DISABLED;
         conv_cnt_q <= 5'h00;
      end else begin
         if (!enabled && !sw_start) begin
            state_q <= ST_DISABLED;
         end else if (sw_start || hw_start || wr_cfg || wr_cmp) begin
            state_q <= (sw_start || hw_start) ? ST_CONVERT : ST_IDLE;
         end else if (conv_done) begin
            state_q <= (continuous_q || (compare_enable_q && !cmp_true && continuous_q)) ? ST_CONVERT
                       : ST_IDLE;
         end else if (state_q == ST_DISABLED) begin
            state_q <= ST_IDLE;
         end
         if (!running || sw_start || hw_start) begin
            conv_cnt_q <= 5'h00;
         end else if (conv_tick) begin
            conv_cnt_q <= conv_done ? 5'h00 : 5'(conv_cnt_q + 5'h01);
         end
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         channel_select_q <= CHAN_ALL_ONES;
         complete_irq_enable_q <= 1'b0;
         continuous_q <= 1'b0;
         compare_enable_q <= 1'b0;
         compare_greater_q <= 1'b0;
         hw_trigger_enable_q <= 1'b0;
         input_clock_select_q <= CLKSEL_BUS;
         clock_divide_select_q <= 2'h0;
         resolution_q <= RES_8BIT;
         compare_value_q <= 10'h000;
         analog_pin_disable_hi_q <= PIN_DISABLE_RESET;
      end else begin
         if (wr_sc1) begin
            channel_select_q <= HWDATA[4:0];
            continuous_q <= HWDATA[5];
            complete_irq_enable_q <= HWDATA[6];
         end
         if (wr_cfg) begin
            input_clock_select_q <= HWDATA[1:0];
            resolution_q <= HWDATA[3:2];
            clock_divide_select_q <= HWDATA[5:4];
            hw_trigger_enable_q <= HWDATA[6];
            compare_enable_q <= HWDATA[7];
            compare_greater_q <= HWDATA[8];
         end
         if (wr_cmp) compare_value_q <= HWDATA[9:0];
         if (wr_pin) analog_pin_disable_hi_q <= HWDATA[7:0];
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         result_q <= 10'h000;
         conversion_complete_flag_q <= 1'b0;
      end else begin
         if (store) result_q <= compare_enable_q ? cmp_res : rounded;
         // Set wins over the clear caused by writes or a low result read.
         if (store) begin
            conversion_complete_flag_q <= 1'b1;
         end else if (wr_sc1 || wr_cfg || wr_cmp || rd_low) begin
            conversion_complete_flag_q <= 1'b0;
         end
      end
   end
   assign COMPLETE_IRQ = conversion_complete_flag_q && complete_irq_enable_q;
   assign CONVERTER_ACTIVE = running;
   assign ASYNC_CLOCK_ENABLE = running && (input_clock_select_q == CLKSEL_ASYNC) && !LOW_POWER_MODE
                               || running && (input_clock_select_q == CLKSEL_ASYNC);

   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++) begin : g_pin
         wire dis = analog_pin_disable_hi_q[g];
         assign PIN_OUT_ENABLE[g] = PORT_OUT_ENABLE[g] && !dis;
         assign PIN_PULLUP_ENABLE[g] = PORT_PULLUP_ENABLE[g] && !dis;
         assign PIN_INPUT_BUFFER_ENABLE[g] = !dis;
         assign PORT_READ_DATA[g] = PIN_INPUT[g] && !dis;
      end
   endgenerate

   logic [31:0] rdata;
   always_comb begin
      rdata = 32'h0000_0000;
      unique case (ph_addr_q)
         OFF_STATUS_CTRL: rdata = {24'h0, conversion_complete_flag_q, complete_irq_enable_q, continuous_q,
                                   channel_select_q};
         OFF_CONFIG: rdata = {23'h0, compare_greater_q, compare_enable_q, hw_trigger_enable_q,
                              clock_divide_select_q, resolution_q, input_clock_select_q};
         OFF_RESULT_HIGH: rdata = {30'h0, result_q[9:8]};
         OFF_RESULT_LOW: rdata = {24'h0, result_q[7:0]};
         OFF_COMPARE: rdata = {22'h0, compare_value_q};
         OFF_PIN_DISABLE_HI: rdata = {24'h0, analog_pin_disable_hi_q};
         default: rdata = 32'h0000_0000;
      endcase
   end
   assign HRDATA = rdata;

   a_disabled_all_ones: assert property (@(posedge CLK) disable iff (!rst_n)
      (!enabled && !sw_start) |=> (state_q == ST_DISABLED)) else $error("Not disabled.");
   a_idle_after_done: assert property (@(posedge CLK) disable iff (!rst_n)
      (conv_done && !continuous_q && enabled && !sw_start && !hw_start && !wr_cfg && !wr_cmp)
      |=> (state_q == ST_IDLE)) else $error("Not idle after single conversion.");
   a_flag_on_store: assert property (@(posedge CLK) disable iff (!rst_n)
      store |=> conversion_complete_flag_q) else $error("Flag not set.");
   a_irq_follows: assert property (@(posedge CLK) disable iff (!rst_n)
      (store && complete_irq_enable_q && !wr_sc1) |=> COMPLETE_IRQ) else $error("No interrupt.");
   a_round_8bit: assert property (@(posedge CLK) disable iff (!rst_n)
      (store && !res10 && !compare_enable_q) |=> (result_q[9:8] == 2'b00)) else $error("High bits set.");
   a_trig_ignored: assert property (@(posedge CLK) disable iff (!rst_n)
      (running && trig_rise && !wr_sc1 && !wr_cfg && !wr_cmp && !conv_done && enabled)
      |=> (conv_cnt_q != 5'h00 || $past(conv_cnt_q) == 5'h00)) else $error("Edge restarted.");
   a_trig_starts: assert property (@(posedge CLK) disable iff (!rst_n)
      (hw_start && enabled) |=> running) else $error("Trigger missed.");
   a_pin_tristate: assert property (@(posedge CLK) disable iff (!rst_n)
      (analog_pin_disable_hi_q != 8'h00) |-> ((PIN_OUT_ENABLE & analog_pin_disable_hi_q) == 8'h00
      && (PORT_READ_DATA & analog_pin_disable_hi_q) == 8'h00)) else $error("Pin driven.");
   c_store_10bit: cover property (@(posedge CLK) disable iff (!rst_n) store && res10);
   c_hw_start: cover property (@(posedge CLK) disable iff (!rst_n) hw_start);
   c_cmp_miss: cover property (@(posedge CLK) disable iff (!rst_n) conv_done && compare_enable_q && !cmp_true);
endmodule

/* File: verification/adc_analog_source.sv */
// Purpose: Far-side model of the analog pins, the clock sources and the trigger source.
// Assumes: Source enables are derived from the bus clock.
// Notes: One fire request gives a four-cycle trigger pulse.
`timescale 1ns/10ps
module adc_analog_source (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic fire,
   input wire logic [10:0] level,
   output logic trig,
   output logic [10:0] sample,
   output logic alt_tick,
   output logic async_tick
);
   logic [2:0] pulse_q;
   logic [1:0] alt_q;
   logic async_q;
   assign trig = pulse_q != 3'h0;
   assign sample = level;
   assign alt_tick = alt_q == 2'h2;
   assign async_tick = async_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pulse_q <= 3'h0;
         alt_q <= 2'h0;
         async_q <= 1'b0;
      end else begin
         pulse_q <= fire ? 3'h4 : pulse_q - {2'h0, trig};
         alt_q <= alt_tick ? 2'h0 : alt_q + 2'h1;
         async_q <= ~async_q;
      end
   end
endmodule

/* File: verification/adc_control_pin_trigger_tb_top.sv */
// Purpose: Register-level test of the converter control block.
// Assumes: Zero-wait AHB-Lite slave, conversion of 24 converter ticks.
// Notes: Conversion length is judged against the tick ratio of each source.
`timescale 1ns/10ps
module adc_control_pin_trigger_tb_top
   import adc_ctl_pkg::*;
;
   logic clk = 0, rst_n = 0, hsel = 0, hwrite = 0, fire = 0, lpm = 0;
   logic [31:0] haddr = 0, hwdata = 0, rd, hrdata;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 0;
   logic [10:0] level = 0, sample;
   logic [7:0] port_oe = 0, port_pu = 0, pin_in = 0, pin_oe, pin_pu, pin_ibe, port_rd;
   logic hreadyout, hresp, trig, alt_tick, async_tick, active, async_en, irq, aen;
   logic [9:0] e10;
   logic [7:0] e8;
   logic [10:0] smp [4] = '{11'h2AB, 11'h7FF, 11'h001, 11'h7FC};
   int clk_tab [8][3] = '{'{0,0,1}, '{0,3,8}, '{1,0,2}, '{1,3,16}, '{2,0,3}, '{3,0,2}, '{0,1,2}, '{0,2,4}};
   int fails = 0, samples_checked = 0, n;
   always #50 clk = ~clk;
   adc_analog_source src_u (.clk(clk), .rst_n(rst_n), .fire(fire), .level(level), .trig(trig),
      .sample(sample), .alt_tick(alt_tick), .async_tick(async_tick));
   adc_control dut_u (.CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
      .HREADYOUT(hreadyout), .HRESP(hresp), .HW_TRIGGER_INPUT(trig), .ALT_CLOCK_TICK(alt_tick),
      .ASYNC_CLOCK_TICK(async_tick), .LOW_POWER_MODE(lpm), .SAMPLE_VALUE(sample),
      .PORT_OUT_ENABLE(port_oe), .PORT_PULLUP_ENABLE(port_pu), .PIN_INPUT(pin_in),
      .PIN_OUT_ENABLE(pin_oe), .PIN_PULLUP_ENABLE(pin_pu), .PIN_INPUT_BUFFER_ENABLE(pin_ibe),
      .PORT_READ_DATA(port_rd), .CONVERTER_ACTIVE(active), .ASYNC_CLOCK_ENABLE(async_en),
      .COMPLETE_IRQ(irq));
   task tally_and_finish;
      if (fails == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wait_ready;
      int k;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (hreadyout !== 1'b1 && k < 50);
      if (k >= 50) begin
         fails++;
         tally_and_finish();
      end
   endtask
   task bus(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h0, addr};
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= 3'h2;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wdata;
      wait_ready();
      rd = hrdata;
   endtask
   task wr(input logic [7:0] addr, input logic [31:0] d);
      bus(1'b1, addr, d);
   endtask
   task rd_check(input logic [7:0] addr, input logic [31:0] exp);
      bus(1'b0, addr, 32'h0);
      check(rd, exp);
   endtask
   task wait_active(input logic lvl, output int cnt);
      cnt = 0;
      while (active !== lvl && cnt < 2000) begin
         @(posedge clk);
         cnt++;
      end
      if (cnt >= 2000) begin
         fails++;
         tally_and_finish();
      end
   endtask
   task wait_irq(output int cnt);
      cnt = 0;
      do begin
         @(posedge clk);
         cnt++;
      end while (irq !== 1'b1 && cnt < 2000);
      if (cnt >= 2000) begin
         fails++;
         tally_and_finish();
      end
   endtask
   task pulse;
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
   endtask
   task convert(input logic [31:0] cfg, input logic [10:0] s, output int cnt);
      int c0;
      wr(OFF_CONFIG, cfg);
      level <= s;
      wr(OFF_STATUS_CTRL, 32'h40);
      wait_active(1'b1, c0);
      aen = async_en;
      wait_active(1'b0, cnt);
      cnt += c0;
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      rd_check(OFF_PIN_DISABLE_HI, 32'h0);
      rd_check(OFF_STATUS_CTRL, 32'h1F);
      rd_check(OFF_CONFIG, 32'h0);
      check({31'h0, active}, 32'h0);
      wr(8'h18, 32'hFF);
      rd_check(8'h18, 32'h0);
      check({31'h0, hresp}, 32'h0);
      port_oe <= 8'hFF;
      port_pu <= 8'hFF;
      pin_in <= 8'h3C;
      for (int p = 0; p < 2; p++) begin
         wr(OFF_PIN_DISABLE_HI, p ? 32'h81 : 32'hA5);
         rd_check(OFF_PIN_DISABLE_HI, p ? 32'h81 : 32'hA5);
         e8 = p ? 8'h7E : 8'h5A;
         check({24'h0, pin_oe}, {24'h0, e8});
         check({24'h0, pin_pu}, {24'h0, e8});
         check({24'h0, pin_ibe}, {24'h0, e8});
         check({24'h0, port_rd}, {24'h0, e8 & 8'h3C});
      end
      for (int i = 0; i < 4; i++) begin
         for (int m = 0; m < 2; m++) begin
            e10 = smp[i] == 11'h7FF ? 10'h3FF : 10'((smp[i] + 12'h1) >> 1);
            e8 = smp[i][10:2] == 9'h1FF ? 8'hFF : 8'((smp[i][10:2] + 10'h1) >> 1);
            convert(m ? {28'h0, RES_10BIT, 2'h0} : {28'h0, RES_8BIT, 2'h0}, smp[i], n);
            check({31'h0, irq}, 32'h1);
            rd_check(OFF_STATUS_CTRL, 32'hC0);
            if (m) rd_check(OFF_RESULT_HIGH, {30'h0, e10[9:8]});
            rd_check(OFF_RESULT_LOW, {24'h0, m ? e10[7:0] : e8});
            @(posedge clk);
            check({31'h0, irq}, 32'h0);
            check({31'h0, active}, 32'h0);
         end
      end
      lpm <= 1'b1;
      for (int t = 0; t < 8; t++) begin
         convert({26'h0, 2'(clk_tab[t][1]), 2'h0, 2'(clk_tab[t][0])}, 11'h100, n);
         check({31'h0, n >= 23 * clk_tab[t][2] && n <= 25 * clk_tab[t][2] + 8}, 32'h1);
         check({31'h0, aen}, {31'h0, clk_tab[t][0] == 3});
      end
      lpm <= 1'b0;
      wr(OFF_COMPARE, 32'h50);
      convert(32'h180, 11'h100, n);
      check({31'h0, irq}, 32'h0);
      rd_check(OFF_STATUS_CTRL, 32'h40);
      convert(32'h080, 11'h100, n);
      check({31'h0, irq}, 32'h1);
      rd_check(OFF_RESULT_LOW, 32'hD0);
      wr(OFF_CONFIG, 32'h40);
      wr(OFF_STATUS_CTRL, 32'h00);
      repeat (5) @(posedge clk);
      check({31'h0, active}, 32'h0);
      pulse();
      wait_active(1'b1, n);
      check({31'h0, n <= 8}, 32'h1);
      repeat (8) @(posedge clk);
      pulse();
      wait_active(1'b0, n);
      check({31'h0, n < 24}, 32'h1);
      repeat (40) @(posedge clk);
      check({31'h0, active}, 32'h0);
      wr(OFF_CONFIG, 32'h0);
      pulse();
      repeat (20) @(posedge clk);
      check({31'h0, active}, 32'h0);
      wr(OFF_CONFIG, 32'h40);
      wr(OFF_STATUS_CTRL, 32'h1F);
      pulse();
      repeat (20) @(posedge clk);
      check({31'h0, active}, 32'h0);
      wr(OFF_STATUS_CTRL, 32'h60);
      pulse();
      wait_active(1'b1, n);
      wait_irq(n);
      repeat (4) @(posedge clk);
      pulse();
      rd_check(OFF_RESULT_LOW, 32'h20);
      wait_irq(n);
      check({31'h0, n < 20}, 32'h1);
      rd_check(OFF_STATUS_CTRL, 32'hE0);
      wr(OFF_STATUS_CTRL, 32'h1F);
      repeat (5) @(posedge clk);
      check({31'h0, active}, 32'h0);
      tally_and_finish();
   end
endmodule
